// ### ccp_pkg.sv
// ccp_pkg: constants for the codec control port
// assumes: shared by the control port top and the testbench
package ccp_pkg;
	localparam logic [6:0] CCP_SLAVE_BASE  = 7'h0a;
	localparam int         CCP_SLAVE_NBIT  = 5;
	localparam int         CCP_SPI_BITS    = 32;
	localparam int         CCP_WORD_BITS   = 16;
	localparam logic [15:0] CCP_ADDR_RST   = 16'h0000;
	localparam int         CCP_SYNC_STAGES = 2;
endpackage

// ### ccp_sync.sv
// ccp_sync: two-stage level synchroniser
// assumes: input comes from outside the core_clk domain
`timescale 1ns/10ps
module ccp_sync (
	input  wire logic core_clk,
	input  wire logic rst_b,
	input  wire logic async_in,
	output logic      sync_out
);
	logic meta_r;

	// meta_r read only by sync_out
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r   <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule // ccp_sync

// ### ccp_top.sv
// ccp_top: slave control port, two-wire or four-wire write-only
// assumes: external master drives the serial clock; register file lies outside
`timescale 1ns/10ps
// Functional notes
// - 16-bit address and data, MSB first
// - read: set address, restart, read, nack, stop
// - write pairs auto-increment the address
// - read pairs auto-increment until nack
// - start or stop aborts current command
// - read without address uses retained address
// - four-wire: select, clock, data pins
// - four-wire mode writes only, no readback
// - select rise: last 32 bits, addr then data
// - slave address 0n01010, n from pin
// - device always slave, master clocks
// - strap low two-wire, high four-wire
module ccp_top (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        port_sel_strap,
	input  wire logic        addr_bit_or_chip_select_pin,
	input  wire logic        ctrl_clk_pin,
	input  wire logic        ctrl_data_in,
	output logic             ctrl_data_out,
	output logic             ctrl_data_oe,
	output logic [15:0]      reg_addr,
	output logic [15:0]      reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic [15:0] reg_rdata
);
	// -------------------------------------------------------------
	// synchronisers
	// -------------------------------------------------------------
	logic scl_s, sda_s, cs_s, strap_s;
	ccp_sync u_scl (.core_clk(core_clk), .rst_b(rst_b), .async_in(ctrl_clk_pin),
		.sync_out(scl_s));
	ccp_sync u_sda (.core_clk(core_clk), .rst_b(rst_b), .async_in(ctrl_data_in),
		.sync_out(sda_s));
	ccp_sync u_cs (.core_clk(core_clk), .rst_b(rst_b),
		.async_in(addr_bit_or_chip_select_pin), .sync_out(cs_s));
	ccp_sync u_strap (.core_clk(core_clk), .rst_b(rst_b), .async_in(port_sel_strap),
		.sync_out(strap_s));

	logic scl_d_r, sda_d_r, cs_d_r, started_r, four_wire_r;
	logic [1:0] settle_r;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			cs_d_r  <= 1'b1;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
			cs_d_r  <= cs_s;
		end
	end

	// strap caught once the synchroniser has settled; mode fixed thereafter
	// sampling earlier would see the synchroniser's reset level, not the strap
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			settle_r    <= 2'd0;
			started_r   <= 1'b0;
			four_wire_r <= 1'b0;
		end else if (!started_r) begin
			if (settle_r == 2'(ccp_pkg::CCP_SYNC_STAGES)) begin
				started_r   <= 1'b1;
				four_wire_r <= strap_s;
			end else begin
				settle_r <= settle_r + 2'd1;
			end
		end
	end

	wire scl_rise = scl_s & ~scl_d_r;
	wire scl_fall = ~scl_s & scl_d_r;
	// master clocks the link in either mode
	wire i2c_on   = started_r & ~four_wire_r;
	wire spi_on   = started_r & four_wire_r;
	wire start_ev = i2c_on & scl_s & scl_d_r & sda_d_r & ~sda_s;
	wire stop_ev  = i2c_on & scl_s & scl_d_r & ~sda_d_r & sda_s;

	// -------------------------------------------------------------
	// four-wire write-only path
	// -------------------------------------------------------------
	logic [31:0] spi_sr_r;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			spi_sr_r <= 32'h0000_0000;
		end else if (spi_on && !cs_s && scl_rise) begin
			spi_sr_r <= {spi_sr_r[30:0], sda_s};
		end
	end
	wire spi_latch = spi_on & cs_s & ~cs_d_r;

	// -------------------------------------------------------------
	// two-wire slave
	// -------------------------------------------------------------
	typedef enum logic [2:0] {CCP_IDLE, CCP_RXBYTE, CCP_ACK, CCP_TXBYTE, CCP_TXACK}
		ccp_state_e;
	ccp_state_e  st_r;
	logic [2:0]  bit_r;
	logic [7:0]  sr_r;
	logic [1:0]  phase_r;  // 0 dev addr, 1 addr hi, 2 addr lo, 3 data
	logic        hi_r, rw_r, ack_drv_r, tx_drv_r, nack_r;
	logic [15:0] addr_r, tx_word_r;
	logic [7:0]  data_hi_r;
	logic        wr_r, rd_r;

	// address bit n taken from the synchronised pin level
	wire [6:0] my_addr = ccp_pkg::CCP_SLAVE_BASE |
		(7'(cs_s) << ccp_pkg::CCP_SLAVE_NBIT);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r      <= CCP_IDLE;
			bit_r     <= 3'd7;
			sr_r      <= 8'h00;
			phase_r   <= 2'd0;
			hi_r      <= 1'b1;
			rw_r      <= 1'b0;
			ack_drv_r <= 1'b0;
			tx_drv_r  <= 1'b0;
			nack_r    <= 1'b0;
			addr_r    <= ccp_pkg::CCP_ADDR_RST;
			tx_word_r <= 16'h0000;
			data_hi_r <= 8'h00;
			wr_r      <= 1'b0;
			rd_r      <= 1'b0;
		end else begin
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			if (spi_latch) begin
				// addr then data of last 32 bits
				wr_r <= 1'b1;
			end
			if (start_ev || stop_ev) begin
				// abort; addr_r retained for later reads
				st_r      <= start_ev ? CCP_RXBYTE : CCP_IDLE;
				bit_r     <= 3'd7;
				phase_r   <= 2'd0;
				hi_r      <= 1'b1;
				ack_drv_r <= 1'b0;
				tx_drv_r  <= 1'b0;
			end else if (i2c_on) begin
				unique case (st_r)
					CCP_IDLE: ;
					CCP_RXBYTE: if (scl_rise) begin
						sr_r <= {sr_r[6:0], sda_s};
						bit_r <= bit_r - 3'd1;
						if (bit_r == 3'd0) begin
							st_r <= CCP_ACK;
						end
					end
					CCP_ACK: if (scl_fall && !ack_drv_r) begin
						if (phase_r == 2'd0) begin
							if (sr_r[7:1] == my_addr) begin
								ack_drv_r <= 1'b1;
								rw_r      <= sr_r[0];
							end else begin
								st_r <= CCP_IDLE;
							end
						end else begin
							ack_drv_r <= 1'b1;
							unique case (phase_r)
								2'd1: addr_r[15:8] <= sr_r;
								2'd2: addr_r[7:0]  <= sr_r;
								default: begin
									if (hi_r) begin
										data_hi_r <= sr_r;
									end else begin
										wr_r <= 1'b1;
									end
									hi_r <= ~hi_r;
								end
							endcase
						end
					end else if (scl_fall && ack_drv_r) begin
						ack_drv_r <= 1'b0;
						bit_r     <= 3'd7;
						if (phase_r == 2'd0 && rw_r) begin
							tx_word_r <= reg_rdata;
							rd_r      <= 1'b1;
							sr_r      <= reg_rdata[15:8];
							hi_r      <= 1'b0;
							tx_drv_r  <= 1'b1;
							st_r      <= CCP_TXBYTE;
						end else begin
							if (phase_r != 2'd3) begin
								phase_r <= phase_r + 2'd1;
							end
							st_r <= CCP_RXBYTE;
						end
					end
					CCP_TXBYTE: if (scl_fall) begin
						if (bit_r == 3'd0) begin
							tx_drv_r <= 1'b0;
							st_r     <= CCP_TXACK;
						end else begin
							sr_r  <= {sr_r[6:0], 1'b0};
							bit_r <= bit_r - 3'd1;
						end
					end
					CCP_TXACK: begin
						if (scl_rise) begin
							nack_r <= sda_s;
						end
						if (scl_fall) begin
							if (nack_r) begin
								st_r <= CCP_IDLE;
								if (!hi_r) begin
									addr_r <= addr_r + 16'h0001;
								end
							end else begin
								bit_r    <= 3'd7;
								tx_drv_r <= 1'b1;
								st_r     <= CCP_TXBYTE;
								if (hi_r) begin
									sr_r      <= reg_rdata[15:8];
									tx_word_r <= reg_rdata;
									rd_r      <= 1'b1;
								end else begin
									sr_r   <= tx_word_r[7:0];
									addr_r <= addr_r + 16'h0001;
								end
								hi_r <= ~hi_r;
							end
						end
					end
					default: st_r <= CCP_IDLE;
				endcase
			end
			if (wr_r && i2c_on) begin
				addr_r <= addr_r + 16'h0001;
			end
		end
	end

	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_addr  <= 16'h0000;
			reg_wdata <= 16'h0000;
		end else if (spi_latch) begin
			reg_addr  <= spi_sr_r[31:16];
			reg_wdata <= spi_sr_r[15:0];
		end else if (i2c_on && st_r == CCP_ACK && scl_fall && !ack_drv_r
				&& phase_r == 2'd3 && !hi_r) begin
			reg_addr  <= addr_r;
			reg_wdata <= {data_hi_r, sr_r};
		end else if (i2c_on) begin
			// read data is looked up from reg_addr, so it follows the current address
			reg_addr <= addr_r;
		end
	end

	// open-drain: drive low only; read path absent in four-wire mode
	assign reg_wr        = wr_r;
	assign reg_rd        = rd_r;
	assign ctrl_data_out = 1'b0;
	assign ctrl_data_oe  = i2c_on & (ack_drv_r | (tx_drv_r & ~sr_r[7]));
endmodule // ccp_top

// ### ccp_checker.sv
// ccp_checker: port assertions for ccp_top
// assumes: bound into ccp_top, single clock domain
`timescale 1ns/10ps
module ccp_checker (
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic        port_sel_strap,
	input wire logic        addr_bit_or_chip_select_pin,
	input wire logic        ctrl_data_oe,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd
);
	// ----
	// checks
	// ----
	wire logic spi = port_sel_strap;
	wire logic sel = addr_bit_or_chip_select_pin;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	a_wr_one_cycle: assert property (reg_wr |=> !reg_wr)
		else $error("long write");
	a_rd_one_cycle: assert property (reg_rd |=> !reg_rd)
		else $error("long read");
	a_spi_no_drive: assert property (spi |-> !ctrl_data_oe)
		else $error("drive in spi");
	a_spi_no_read: assert property (spi |-> !reg_rd)
		else $error("read in spi");
	a_wdata_held: assert property ($changed(reg_wdata) |-> reg_wr)
		else $error("wdata moved");
	a_spi_sel_write: assert property (spi && $rose(sel) |-> ##[1:8] reg_wr)
		else $error("no write on select");
	// write only once select has been released for a while
	a_spi_wr_after: assert property (spi && reg_wr |-> $past(sel, 2))
		else $error("write while selected");
	a_i2c_wr_acked: assert property (!spi && reg_wr |-> ##[0:4] ctrl_data_oe)
		else $error("write without ack");
	c_i2c_write: cover property (!spi && reg_wr);
	c_spi_write: cover property (spi && reg_wr);
	c_read: cover property (reg_rd);
endmodule // ccp_checker
bind ccp_top ccp_checker u_chk (.core_clk, .rst_b, .port_sel_strap,
	.addr_bit_or_chip_select_pin, .ctrl_data_oe, .reg_wdata, .reg_wr, .reg_rd);

// ### ccp_host_model.sv
// ccp_host_model: external bus master, 64 ns bit time
// assumes: bench resolves the pulled-up data line
`timescale 1ns/10ps
module ccp_host_model (
	output logic      scl,
	output logic      sda_oe,
	output logic      mosi,
	output logic      ss_b,
	input  wire logic sda
);
	// ----
	// link tasks
	// ----
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
		mosi = 1'b0;
		ss_b = 1'b1;
	end
	// data moves only while clock low
	task automatic bit_io(input logic b, output logic s);
		sda_oe = ~b;
		#16 scl = 1'b1;
		#16 s = sda;
		#16 scl = 1'b0;
		#16;
	endtask
	// also a repeated start; releases data before raising the clock
	task automatic start_c();
		sda_oe = 1'b0;
		#32 scl = 1'b1;
		#32 sda_oe = 1'b1;
		#16 scl = 1'b0;
		#16;
	endtask
	task automatic stop_c();
		sda_oe = 1'b1;
		#16 scl = 1'b1;
		#16 sda_oe = 1'b0;
		#32;
	endtask
	// clock pulled low at frame start and left low after the frame
	task automatic spi_frame(input logic [63:0] v, input int n);
		scl = 1'b0;
		ss_b = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			mosi = v[i];
			#16 scl = 1'b1;
			#32 scl = 1'b0;
			#16;
		end
		ss_b = 1'b1;
		mosi = ~mosi;
		#64;
	endtask
endmodule // ccp_host_model

// ### tb.sv
// tb: self-checking bench for ccp_top, both port modes
// assumes: register file here, read data a pure function of address
`timescale 1ns/10ps
module tb;
	// ----
	// bench
	// ----
	logic        core_clk = 1'b0;
	logic        rst_b, strap, cs_lvl, scl, m_oe, mosi, ss_b, oe, reg_wr, reg_rd, sda_o;
	logic [15:0] reg_addr, reg_wdata;
	logic [31:0] seed = 32'h0000_63a7;
	logic [31:0] expq[$];
	int          mismatches = 0;
	int          checked = 0;
	wire logic   line = strap ? mosi : (~m_oe & (oe ? sda_o : 1'b1));
	always #4 core_clk = ~core_clk;
	ccp_top dut (.core_clk, .rst_b, .port_sel_strap(strap),
		.addr_bit_or_chip_select_pin(strap ? ss_b : cs_lvl), .ctrl_clk_pin(scl),
		.ctrl_data_in(line), .ctrl_data_out(sda_o), .ctrl_data_oe(oe), .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata(reg_addr ^ 16'h5a3c));
	ccp_host_model host (.scl, .sda_oe(m_oe), .mosi, .ss_b, .sda(line));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] sa(input logic rw);
		return {ccp_pkg::CCP_SLAVE_BASE | (7'(cs_lvl) << ccp_pkg::CCP_SLAVE_NBIT), rw};
	endfunction
	// controller side field update: clear with mask, insert new bits
	function automatic logic [15:0] fld(input logic [15:0] w, input logic [15:0] m,
		input logic [15:0] v);
		return (w & m) | v;
	endfunction
	task automatic check(input logic ok, input string msg);
		checked++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("ERROR %0t: %s", $time, msg);
		end
	endtask
	task automatic wbyte(input logic [7:0] b, input logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) host.bit_io(b[i], s);
		host.bit_io(1'b1, s);
		check(s === ~ack, "ack");
	endtask
	task automatic wword(input logic [15:0] w);
		wbyte(w[15:8], 1'b1);
		wbyte(w[7:0], 1'b1);
	endtask
	task automatic rpair(input logic [15:0] a, input logic last);
		logic [15:0] w;
		logic s;
		for (int i = 15; i >= 0; i--) begin
			host.bit_io(1'b1, w[i]);
			if (i == 8 || i == 0) host.bit_io(i == 0 && last, s);
		end
		check(w === (a ^ 16'h5a3c), "read data");
	endtask
	task automatic reset_dut(input logic s);
		rst_b <= 1'b0;
		strap <= s;
		cs_lvl <= seed[3];
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (6) @(posedge core_clk);
		#3;
	endtask
	task automatic drain();
		for (int i = 0; i < 50 && expq.size() != 0; i++) @(posedge core_clk);
		check(expq.size() == 0, "write missing");
	endtask
	task automatic wrap_up();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge core_clk) begin
		if (reg_wr === 1'b1) begin
			check(expq.size() != 0 && {reg_addr, reg_wdata} === expq[0], "write");
			if (expq.size() != 0) void'(expq.pop_front());
		end
	end
	initial begin
		logic [15:0] a, d0, d1;
		logic [63:0] v;
		rst_b = 1'b0;
		strap = 1'b0;
		cs_lvl = 1'b1;
		reset_dut(1'b0);
		a = 16'(rnd());
		d0 = 16'(rnd());
		d1 = 16'(rnd());
		expq.push_back({a, d0});
		expq.push_back({a + 16'h0001, d1});
		host.start_c();
		wbyte(sa(1'b0), 1'b1);
		wword(a);
		wword(d0);
		wword(d1);
		host.stop_c();
		host.start_c();
		wbyte(sa(1'b0), 1'b1);
		wword(a);
		host.start_c();
		wbyte(sa(1'b1), 1'b1);
		rpair(a, 1'b0);
		rpair(a + 16'h0001, 1'b1);
		host.stop_c();
		host.start_c();
		wbyte(sa(1'b1), 1'b1);
		rpair(a + 16'h0002, 1'b1);
		host.stop_c();
		host.start_c();
		wbyte(sa(1'b0) ^ (8'h01 << (ccp_pkg::CCP_SLAVE_NBIT + 1)), 1'b0);
		wbyte(8'h12, 1'b0);
		host.stop_c();
		// odd byte cut by stop is dropped, address kept
		host.start_c();
		wbyte(sa(1'b0), 1'b1);
		wword(16'hffff);
		wbyte(8'h5a, 1'b1);
		host.stop_c();
		host.start_c();
		wbyte(sa(1'b1), 1'b1);
		rpair(16'hffff, 1'b0);
		rpair(16'h0000, 1'b1);
		host.stop_c();
		// read-modify-write of one field
		host.start_c();
		wbyte(sa(1'b0), 1'b1);
		wword(a);
		host.start_c();
		wbyte(sa(1'b1), 1'b1);
		rpair(a, 1'b1);
		host.stop_c();
		d0 = fld(a ^ 16'h5a3c, 16'hff0f, d1 & 16'h00f0);
		expq.push_back({a, d0});
		host.start_c();
		wbyte(sa(1'b0), 1'b1);
		wword(a);
		wword(d0);
		host.stop_c();
		drain();
		reset_dut(1'b1);
		v = {rnd(), rnd()};
		expq.push_back(v[31:0]);
		host.spi_frame(v, 40);
		v = {rnd(), rnd()};
		expq.push_back(v[31:0]);
		host.spi_frame(v, 32);
		drain();
		wrap_up();
	end
endmodule // tb
